// >>> verilog/txmc_pkg.sv
// Purpose: constants for the transmit modem-control setup block
// Assumes: 32-bit AXI4-Lite register bus, 125 MHz clock
// Notes:   offsets and field positions used by the block and its timer
`default_nettype none
package txmc_pkg;
    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] TXMC_CMD_OFF    = 8'h00; // command code, write starts
    localparam logic [7:0] TXMC_P1_OFF     = 8'h04; // first_parameter_longword
    localparam logic [7:0] TXMC_P2_OFF     = 8'h08; // second_parameter_longword
    localparam logic [7:0] TXMC_STAT_OFF   = 8'h0c; // sticky events, read clears
    localparam logic [7:0] TXMC_MASK_OFF   = 8'h10; // interrupt mask
    localparam logic [7:0] TXMC_LINES_OFF  = 8'h14; // out lines, in lines, state
    localparam logic [7:0] TXMC_CMD_XMIT   = 8'h20; // transmit command code
    // ****************************************************************
    // first parameter fields
    // ****************************************************************
    localparam int TXMC_NEW_LSB   = 0;
    localparam int TXMC_NEW_W     = 5;
    localparam int TXMC_CHG_BIT   = 7;
    localparam int TXMC_CHK_BIT   = 8;
    localparam int TXMC_REQ_LSB   = 9;
    localparam int TXMC_REQ_W     = 7;
    localparam int TXMC_MEN_BIT   = 16;
    localparam int TXMC_MSK_LSB   = 17;
    localparam int TXMC_TMO_W     = 16;
    // ****************************************************************
    // status bits
    // ****************************************************************
    localparam int TXMC_ST_GO     = 0; // transmission released
    localparam int TXMC_ST_TMO    = 1; // wait timed out
    localparam int TXMC_ST_BADCMD = 2; // unknown command code
    localparam int TXMC_ST_W      = 3;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int TXMC_CLK_MHZ   = 125;
    localparam int TXMC_TICK_MS   = 10;
    localparam int TXMC_TICK_CYC  = TXMC_TICK_MS * 1000 * TXMC_CLK_MHZ;
    localparam logic [1:0] TXMC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] TXMC_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> verilog/txmc_tick.sv
// Purpose: free-running 10 ms tick generator
// Assumes: period given in clock cycles
// Notes:   restarts whenever clr is high
`default_nettype none
module txmc_tick
    import txmc_pkg::*;
#(
    parameter int PERIOD = TXMC_TICK_CYC
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic clr,
    output logic      tick
);
    logic [31:0] cnt_reg;
    wire         at_end = (cnt_reg == 32'(PERIOD - 1));

    // ****************************************************************
    // count cycles, pulse at end of each period
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 32'h0;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= (clr || at_end) ? 32'h0 : cnt_reg + 32'h1;
            tick    <= !clr && at_end;
        end
    end
endmodule // txmc_tick
`default_nettype wire

// >>> verilog/txmc_top.sv
// Purpose: decode the transmit modem-control longwords, set lines, wait on lines
// Assumes: registers over AXI4-Lite; incoming lines synchronous to clock
// Notes:   tx_go pulses when transmission may begin
`default_nettype none
// Behaviour
// - bits 4:0 give new outgoing line state
// - bit order: 140,108/2,111,141,105
// - apply new state only when bit 7 set
// - check incoming state only when bit 8
// - hold transmit until lines match bits 15:9
// - bits 23:17 mask required bits 9 to 15
// - mask used only when bit 16 set; with it clear no line is compared
// - command 0x20 is transmit with parameters
// - timeout after P2 low times 10 ms, zero never
module txmc_top
    import txmc_pkg::*;
#(
    parameter int TICK_CYC = TXMC_TICK_CYC
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             remote_loop,
    output logic             term_ready,
    output logic             rate_select,
    output logic             local_loop,
    output logic             req_to_send,
    input  wire logic [6:0]  modem_in,
    output logic             tx_go,
    output logic             tx_busy,
    output logic             irq
);
    typedef enum logic [1:0] {
        TXMC_IDLE = 2'b00,
        TXMC_SET  = 2'b01,
        TXMC_WAIT = 2'b10
    } txmc_state_e;

    txmc_state_e     state_reg;
    logic [31:0]     p1_reg;
    logic [31:0]     p2_reg;
    logic [4:0]      out_reg;
    logic [15:0]     tmo_reg;
    logic [TXMC_ST_W-1:0] stat_reg;
    logic [TXMC_ST_W-1:0] mask_reg;
    logic            aw_held_reg, w_held_reg;
    logic [7:0]      awaddr_reg;
    logic [31:0]     wdata_reg;
    logic [3:0]      wstrb_reg;
    logic            tick;

    // merge a write into a register under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            if (be[i]) old[i*8 +: 8] = d[i*8 +: 8];
        end
        return old;
    endfunction

    // ****************************************************************
    // write channel: address and data taken in either order
    // ****************************************************************
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire  = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_reg || aw_fire;
    wire w_have  = w_held_reg || w_fire;
    wire wr_do   = aw_have && w_have;
    wire [7:0]  wa = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wd = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [3:0]  wb = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire wr_cmd  = wr_do && (wa == TXMC_CMD_OFF);
    wire wr_p1   = wr_do && (wa == TXMC_P1_OFF);
    wire wr_p2   = wr_do && (wa == TXMC_P2_OFF);
    wire wr_mask = wr_do && (wa == TXMC_MASK_OFF);
    wire wr_ok   = wr_cmd || wr_p1 || wr_p2 || wr_mask ||
                   (wa == TXMC_STAT_OFF) || (wa == TXMC_LINES_OFF);
    // a command is taken only when idle and byte 0 is written
    wire cmd_take = wr_cmd && wb[0] && (state_reg == TXMC_IDLE);
    wire cmd_xmit = cmd_take && (wd[7:0] == TXMC_CMD_XMIT);
    wire cmd_bad  = cmd_take && (wd[7:0] != TXMC_CMD_XMIT);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 8'h0;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= TXMC_RESP_OKAY;
        end else begin
            if (aw_fire) awaddr_reg <= s_axi_awaddr;
            if (w_fire) wdata_reg <= s_axi_wdata;
            if (w_fire) wstrb_reg <= s_axi_wstrb;
            aw_held_reg <= aw_have && !wr_do;
            w_held_reg  <= w_have && !wr_do;
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? TXMC_RESP_OKAY : TXMC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire rd_stat = rd_fire && (s_axi_araddr == TXMC_STAT_OFF);
    wire [31:0] lines_word = {16'h0, 2'b0, state_reg, modem_in, out_reg};
    wire [31:0] rd_word =
        (s_axi_araddr == TXMC_CMD_OFF)   ? 32'h0 :
        (s_axi_araddr == TXMC_P1_OFF)    ? p1_reg :
        (s_axi_araddr == TXMC_P2_OFF)    ? p2_reg :
        (s_axi_araddr == TXMC_STAT_OFF)  ? {29'h0, stat_reg} :
        (s_axi_araddr == TXMC_MASK_OFF)  ? {29'h0, mask_reg} :
        (s_axi_araddr == TXMC_LINES_OFF) ? lines_word : 32'h0;
    wire rd_ok = (s_axi_araddr <= TXMC_LINES_OFF) && (s_axi_araddr[1:0] == 2'b00);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= TXMC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? TXMC_RESP_OKAY : TXMC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // line check: masked compare of required state, all seven incoming lines
    // ****************************************************************
    wire       chk_en  = p1_reg[TXMC_CHK_BIT];
    wire [6:0] req_st  = p1_reg[TXMC_REQ_LSB +: TXMC_REQ_W];
    wire [6:0] sig     = p1_reg[TXMC_MEN_BIT] ?
                         p1_reg[TXMC_MSK_LSB +: TXMC_REQ_W] : 7'h0;
    wire       lines_ok = ((modem_in ^ req_st) & sig) == 7'h0;
    wire [15:0] tmo_lim = p2_reg[TXMC_TMO_W-1:0];
    wire       tmo_hit  = (tmo_lim != 16'h0) && tick && (tmo_reg + 16'h1 >= tmo_lim);
    wire       go_now   = (state_reg == TXMC_WAIT) && (!chk_en || lines_ok);
    wire       tmo_now  = (state_reg == TXMC_WAIT) && !go_now && tmo_hit;

    txmc_tick #(.PERIOD(TICK_CYC)) u_tick (
        .clock (clock),
        .rst_n (rst_n),
        .clr   (state_reg != TXMC_WAIT),
        .tick  (tick)
    );

    // ****************************************************************
    // parameter registers and sequencer
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            p1_reg    <= 32'h0;
            p2_reg    <= 32'h0;
            out_reg   <= 5'h0;
            tmo_reg   <= 16'h0;
            state_reg <= TXMC_IDLE;
            tx_go     <= 1'b0;
        end else begin
            if (wr_p1 && state_reg == TXMC_IDLE) p1_reg <= merge(p1_reg, wd, wb);
            if (wr_p2 && state_reg == TXMC_IDLE) p2_reg <= merge(p2_reg, wd, wb);
            tx_go <= go_now;
            case (state_reg)
                TXMC_IDLE: begin
                    tmo_reg <= 16'h0;
                    if (cmd_xmit) state_reg <= TXMC_SET;
                end
                TXMC_SET: begin
                    // new line state first; bits 5 and 6 never reach the lines
                    if (p1_reg[TXMC_CHG_BIT])
                        out_reg <= p1_reg[TXMC_NEW_LSB +: TXMC_NEW_W];
                    state_reg <= TXMC_WAIT;
                end
                TXMC_WAIT: begin
                    if (tick) tmo_reg <= tmo_reg + 16'h1;
                    if (go_now || tmo_now) state_reg <= TXMC_IDLE;
                end
                default: state_reg <= TXMC_IDLE;
            endcase
        end
    end

    // outgoing circuits in fixed bit order
    assign remote_loop = out_reg[0];
    assign term_ready  = out_reg[1];
    assign rate_select = out_reg[2];
    assign local_loop  = out_reg[3];
    assign req_to_send = out_reg[4];
    assign tx_busy     = (state_reg != TXMC_IDLE);

    // ****************************************************************
    // sticky events, read of status clears, set wins over clear
    // ****************************************************************
    wire [TXMC_ST_W-1:0] ev = {cmd_bad, tmo_now, go_now};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg <= '0;
            mask_reg <= '0;
        end else begin
            stat_reg <= (rd_stat ? '0 : stat_reg) | ev;
            if (wr_mask && wb[0]) mask_reg <= wd[TXMC_ST_W-1:0];
        end
    end
    assign irq = |(stat_reg & mask_reg);

    // ****************************************************************
    // checks
    // ****************************************************************
    a_chg_applies: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == TXMC_SET && p1_reg[TXMC_CHG_BIT]) |=> out_reg == $past(p1_reg[4:0]))
        else $error("new line state not applied");
    a_chg_ignored: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == TXMC_SET && !p1_reg[TXMC_CHG_BIT]) |=> $stable(out_reg))
        else $error("lines changed with change bit clear");
    a_lines_hold: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg != TXMC_SET |=> $stable(out_reg))
        else $error("lines moved outside set step");
    a_no_check_go: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == TXMC_WAIT && !chk_en) |=> tx_go && state_reg == TXMC_IDLE)
        else $error("unchecked wait did not release");
    a_match_go: assert property (@(posedge clock) disable iff (!rst_n)
        tx_go |-> $past(!chk_en || ((modem_in ^ req_st) & sig) == 7'h0))
        else $error("released with lines not matching");
    a_mask_off: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == TXMC_WAIT && !p1_reg[TXMC_MEN_BIT]) |=> tx_go)
        else $error("mask disabled yet not released");
    a_mask_map: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == TXMC_WAIT && chk_en && p1_reg[TXMC_MEN_BIT] &&
         ((modem_in ^ req_st) & p1_reg[23:17]) != 7'h0) |=> !tx_go)
        else $error("released on masked mismatch");
    a_cmd_start: assert property (@(posedge clock) disable iff (!rst_n)
        cmd_xmit |=> state_reg == TXMC_SET ##1 state_reg != TXMC_SET)
        else $error("transmit command not started");
    a_tmo_end: assert property (@(posedge clock) disable iff (!rst_n)
        tmo_now |=> state_reg == TXMC_IDLE && stat_reg[TXMC_ST_TMO])
        else $error("timeout not reported");
    // parameters frozen while a command runs
    a_p1_frozen: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg != TXMC_IDLE |=> $stable(p1_reg))
        else $error("first parameter changed while busy");
    a_p2_frozen: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg != TXMC_IDLE |=> $stable(p2_reg))
        else $error("second parameter changed while busy");
    a_bad_cmd: assert property (@(posedge clock) disable iff (!rst_n)
        cmd_bad |=> stat_reg[TXMC_ST_BADCMD] && state_reg == TXMC_IDLE)
        else $error("unknown command not flagged");
    // release is a single pulse and is always recorded
    a_go_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        tx_go |=> !tx_go)
        else $error("release longer than one cycle");
    a_go_status: assert property (@(posedge clock) disable iff (!rst_n)
        tx_go |-> stat_reg[TXMC_ST_GO])
        else $error("release not recorded");
    a_set_to_wait: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == TXMC_SET |=> state_reg == TXMC_WAIT)
        else $error("set step not followed by wait");
    // timeout only with a nonzero limit and a fresh tick count
    a_zero_no_tmo: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == TXMC_WAIT && p2_reg[15:0] == 16'h0) |-> !tmo_now)
        else $error("timeout with zero limit");
    a_tick_restart: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg != TXMC_WAIT |=> !tick)
        else $error("tick outside wait");
    a_bvalid_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rvalid_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid)
        else $error("read response dropped early");
endmodule // txmc_top
`default_nettype wire

// >>> test/txmc_modem.sv
// Purpose: far-side model of the modem lines seen by the transmit setup block
// Assumes: loopback connector fitted, so the two test inputs echo our own lines
// Notes:   the bench steers the remaining incoming circuits through far_lines
`default_nettype none
module txmc_modem (
    input  wire logic       req_to_send,
    input  wire logic       term_ready,
    input  wire logic [4:0] far_lines,
    output logic [6:0]      modem_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // far_lines: 0 test indicator, 1 clear to send, 2 carrier, 3 ring, 4 set ready
    // looped test signals follow our own request-to-send and terminal-ready
    assign modem_in = {far_lines[4:1], term_ready, far_lines[0], req_to_send};
endmodule // txmc_modem
`default_nettype wire

// >>> test/txmc_top_test.sv
// Purpose: self-checking bench for the transmit modem-control setup block
// Assumes: tick shortened to 20 cycles, registers reached over AXI4-Lite
// Notes:   only transmit commands carry line changes, one interface in use
`default_nettype none
module txmc_top_test
    import txmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // signals, clock and design
    // ****************************************************************
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [4:0]  far = 5'h00;
    wire logic        awready, wready, bvalid, arready, rvalid;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [4:0]  outs;
    wire logic [6:0]  modem_in;
    wire logic        tx_go, tx_busy, irq;
    int          fails = 0;
    int          total_checks = 0;
    logic        g;
    logic [31:0] d;
    logic [1:0]  r;
    // free-running 125 MHz clock
    always #4 clock = ~clock;
    txmc_top #(.TICK_CYC(20)) dut_u (
        .clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .remote_loop(outs[0]), .term_ready(outs[1]), .rate_select(outs[2]),
        .local_loop(outs[3]), .req_to_send(outs[4]), .modem_in(modem_in),
        .tx_go(tx_go), .tx_busy(tx_busy), .irq(irq));
    txmc_modem modem_u (
        .req_to_send(outs[4]), .term_ready(outs[1]), .far_lines(far), .modem_in(modem_in));
    // ****************************************************************
    // compare, verdict and bus tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // a wait that ran out counts as a mismatch and ends the run
    task automatic hung(input string what);
        chk(what, 32'h0, 32'h1);
        tally_and_finish();
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge clock);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clock);
            if (bvalid && bready) begin
                done = 1'b1;
                resp = bresp;
                bready <= 1'b0;
            end
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        if (!done) hung("write response");
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clock);
            if (rvalid && rready) begin
                done = 1'b1;
                v = rdata;
                resp = rresp;
                rready <= 1'b0;
            end
            if (arvalid && arready) arvalid <= 1'b0;
        end
        if (!done) hung("read response");
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        axw(a, v, r);
        chk("write resp", 32'(r), 32'(TXMC_RESP_OKAY));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        axr(a, d, r);
        chk(what, d, exp);
        chk("read resp", 32'(r), 32'(TXMC_RESP_OKAY));
    endtask
    // watch for the one-cycle release pulse over a bounded number of edges
    task automatic wait_go(input int bound, output logic got);
        got = 1'b0;
        for (int n = 0; n < bound && !got; n++) begin
            @(posedge clock);
            if (tx_go === 1'b1) got = 1'b1;
        end
    endtask
    task automatic xmit(input logic [31:0] p1, input logic fast);
        wr(TXMC_P1_OFF, p1);
        wr(TXMC_CMD_OFF, 32'(TXMC_CMD_XMIT));
        wait_go(10, g);
        chk("release", 32'(g), 32'(fast));
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk("lines after reset", 32'(outs), 32'h0);
        chk("flags after reset", 32'({tx_go, tx_busy, irq}), 32'h0);
        rd(TXMC_MASK_OFF, 32'h0, "mask reset");
        wr(TXMC_P2_OFF, 32'h0);
        // each new-state bit alone, with bits 5 and 6 set as noise
        for (int i = 0; i < 5; i++) begin
            xmit(32'h0000_00e0 | (32'h1 << i), 1'b1);
            chk("out lines", 32'(outs), 32'h1 << i);
        end
        xmit(32'h0000_001f, 1'b1);
        chk("lines kept", 32'(outs), 32'h10);
        xmit(32'h00ff_fe00, 1'b1);
        xmit(32'h0000_ff00, 1'b1);
        // clear to send required and masked, set ready required but unmasked
        xmit(32'h0013_9300, 1'b0);
        chk("busy waiting", 32'(tx_busy), 32'h1);
        rd(TXMC_LINES_OFF, 32'h0000_2030, "lines reg");
        far <= 5'h02;
        wait_go(6, g);
        chk("release on match", 32'(g), 32'h1);
        wr(TXMC_MASK_OFF, 32'h2);
        rd(TXMC_STAT_OFF, 32'h1, "status go");
        chk("irq masked", 32'(irq), 32'h0);
        // three ticks then timeout
        far <= 5'h00;
        wr(TXMC_P2_OFF, 32'h3);
        xmit(32'h0011_1100, 1'b0);
        wait_go(40, g);
        chk("no release", 32'(g), 32'h0);
        chk("still waiting", 32'(tx_busy), 32'h1);
        for (int n = 0; n < 40 && tx_busy !== 1'b0; n++) @(posedge clock);
        if (tx_busy !== 1'b0) hung("timeout");
        chk("irq raised", 32'(irq), 32'h1);
        rd(TXMC_STAT_OFF, 32'h2, "status timeout");
        repeat (2) @(posedge clock);
        chk("irq cleared", 32'(irq), 32'h0);
        wr(TXMC_CMD_OFF, 32'h21);
        repeat (3) @(posedge clock);
        rd(TXMC_STAT_OFF, 32'h4, "status bad cmd");
        axr(8'h18, d, r);
        chk("unmapped resp", 32'(r), 32'(TXMC_RESP_SLVERR));
        chk("unmapped data", d, 32'h0);
        axw(8'h18, 32'h5, r);
        chk("unmapped wresp", 32'(r), 32'(TXMC_RESP_SLVERR));
        tally_and_finish();
    end
endmodule // txmc_top_test
`default_nettype wire
